//--- common/dam_defs.vh
// Constants for the dual alarm monitor: register offsets, fields, resets.
// Assumes byte offsets as presented on the internal register port.
`ifndef DAM_DEFS_VH
`define DAM_DEFS_VH

`define DAM_OFS_THR1      7'h26
`define DAM_OFS_THR2      7'h28
`define DAM_OFS_CNT1      7'h2a
`define DAM_OFS_CNT2      7'h2c
`define DAM_OFS_CFG       7'h2e
`define DAM_OFS_STAT      7'h3c

`define DAM_RST_THR       16'h0000
`define DAM_RST_CNT       16'h0000
`define DAM_RST_CFG       16'h0000

`define DAM_THR_DIR       15
`define DAM_THR_MAG_HI    13
`define DAM_CNT_HI        7
`define DAM_CFG_SRC2_HI   15
`define DAM_CFG_SRC2_LO   12
`define DAM_CFG_SRC1_HI   11
`define DAM_CFG_SRC1_LO   8
`define DAM_CFG_DYN2      7
`define DAM_CFG_DYN1      6
`define DAM_CFG_FILT      4
`define DAM_CFG_IND_EN    2
`define DAM_CFG_IND_POL   1
`define DAM_CFG_IND_SEL   0
`define DAM_STAT_ALM1     8
`define DAM_STAT_ALM2     9

`define DAM_SRC_OFF       4'h0
`define DAM_SRC_TEMP      4'h7
`define DAM_HIST_DEPTH    256

`endif

//--- hdl/dam_channel.v
// One alarm channel: source select, static or dynamic compare.
// Assumes sample_stb marks one new sample set on ref_clk.
`include "dam_defs.vh"
`default_nettype none

module dam_channel (
	input  wire         ref_clk,    // System clock
	input  wire         rst_n,      // Sync reset, active low
	input  wire         sample_stb, // New sample set
	input  wire [111:0] src_bus,    // Seven 16-bit sources, gyro x first
	input  wire [3:0]   src_sel,    // Source code
	input  wire         dynamic,    // 1 = dynamic compare
	input  wire [15:0]  thr,        // Threshold register
	input  wire [7:0]   win,        // Sample window
	output reg          hit_r       // Condition on latest sample
);

	reg  [15:0] hist [0:`DAM_HIST_DEPTH-1];
	reg  [7:0]  wr_ptr_r;
	reg  [8:0]  fill_r;
	reg  [3:0]  sel_q_r;
	reg  [7:0]  win_q_r;
	wire [7:0]  win_eff;
	wire [7:0]  rd_ptr;
	wire [15:0] cur;
	wire [15:0] old;
	wire signed [16:0] diff;
	wire signed [16:0] mag;
	wire signed [16:0] val;
	wire        valid_src;
	wire        enough;

	// Both 0 and 1 mean a one-sample window
	assign win_eff = (win == 8'h00) ? 8'h01 : win;
	assign valid_src = (src_sel != `DAM_SRC_OFF) && (src_sel <= `DAM_SRC_TEMP);
	assign cur = valid_src ? src_bus[(src_sel - 4'h1) * 16 +: 16] : 16'h0000;
	assign rd_ptr = wr_ptr_r - win_eff;
	assign old = hist[rd_ptr];
	assign diff = $signed({cur[15], cur}) - $signed({old[15], old});
	// Bits 13:0 hold a positive magnitude in the source's format
	assign mag = $signed({3'b000, thr[`DAM_THR_MAG_HI:0]});
	assign val = dynamic ? diff : $signed({cur[15], cur});
	// N stored samples plus the current one span an N-sample change
	assign enough = fill_r >= {1'b0, win_eff};

	always @(posedge ref_clk)
	begin
		if (sample_stb)
			hist[wr_ptr_r] <= cur;
	end

	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= 8'h00;
			fill_r <= 9'h000;
			hit_r <= 1'b0;
			sel_q_r <= 4'h0;
			win_q_r <= 8'h00;
		end
		else
		begin
			sel_q_r <= src_sel;
			win_q_r <= win;
			// Changing source or window voids the history
			if (sel_q_r != src_sel || win_q_r != win)
			begin
				fill_r <= 9'h000;
				hit_r <= 1'b0;
			end
			else if (sample_stb)
			begin
				wr_ptr_r <= wr_ptr_r + 8'h01;
				if (fill_r != 9'h100)
					fill_r <= fill_r + 9'h001;
				if (!valid_src || (dynamic && !enough))
					hit_r <= 1'b0;
				else if (thr[`DAM_THR_DIR])
					hit_r <= val > mag;
				else
					hit_r <= val < mag;
			end
		end
	end

endmodule

`default_nettype wire

//--- hdl/dam_top.v
// Dual alarm monitor: registers, two channels, status flags, indicator.
// Assumes a single-cycle internal register port and a sample strobe.
`include "dam_defs.vh"
`default_nettype none

module dam_top (
	input  wire         ref_clk,        // 250 MHz clock
	input  wire         rst_n,          // Sync reset, active low
	input  wire         reg_wr,         // Register write strobe
	input  wire         reg_rd,         // Register read strobe
	input  wire [6:0]   reg_addr,       // Register byte offset
	input  wire [15:0]  reg_wdata,      // Write data
	output reg  [15:0]  reg_rdata_r,    // Read data, valid next cycle
	input  wire         sample_stb,     // New sample set, one cycle
	input  wire [111:0] raw_bus,        // Unfiltered sources
	input  wire [111:0] filt_bus,       // Filtered sources
	input  wire         misc_own_one,   // Misc control owns pin one
	input  wire         misc_own_two,   // Misc control owns pin two
	input  wire         gpio_oe_one,    // General I/O drives pin one
	input  wire         gpio_oe_two,    // General I/O drives pin two
	input  wire         gpio_do_one,    // General I/O level pin one
	input  wire         gpio_do_two,    // General I/O level pin two
	output wire         alarm_own_one,  // Alarm owns pin one
	output wire         alarm_own_two,  // Alarm owns pin two
	output reg          gp_one_out_r,   // general_pin_one level
	output reg          gp_one_oe_n_r,  // general_pin_one enable, low
	output reg          gp_two_out_r,   // general_pin_two level
	output reg          gp_two_oe_n_r   // general_pin_two enable, low
);

	reg  [15:0] thr1_r;
	reg  [15:0] thr2_r;
	reg  [15:0] cnt1_r;
	reg  [15:0] cnt2_r;
	reg  [15:0] cfg_r;
	reg  [1:0]  flag_r;
	reg  [1:0]  hit_q_r;
	reg  [1:0]  upd_r;
	wire [1:0]  hit;
	wire [111:0] src_bus;
	wire        ind_act;
	wire        ind_lvl;
	wire        rd_stat;

	function sel_hit;
		input [6:0] a;
		input [6:0] ofs;
		begin
			sel_hit = (a == ofs);
		end
	endfunction

	// Filter choice is shared by both channels
	assign src_bus = cfg_r[`DAM_CFG_FILT] ? filt_bus : raw_bus;

	// Register writes; unused bits are kept so reads echo them
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			thr1_r <= `DAM_RST_THR;
			thr2_r <= `DAM_RST_THR;
			cnt1_r <= `DAM_RST_CNT;
			cnt2_r <= `DAM_RST_CNT;
			cfg_r <= `DAM_RST_CFG;
		end
		else if (reg_wr)
		begin
			if (sel_hit(reg_addr, `DAM_OFS_THR1))
				thr1_r <= reg_wdata;
			if (sel_hit(reg_addr, `DAM_OFS_THR2))
				thr2_r <= reg_wdata;
			if (sel_hit(reg_addr, `DAM_OFS_CNT1))
				cnt1_r <= reg_wdata;
			if (sel_hit(reg_addr, `DAM_OFS_CNT2))
				cnt2_r <= reg_wdata;
			if (sel_hit(reg_addr, `DAM_OFS_CFG))
				cfg_r <= reg_wdata;
		end
	end

	// Two identical, independent channels
	dam_channel u_ch1 (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.sample_stb (sample_stb),
		.src_bus    (src_bus),
		.src_sel    (cfg_r[`DAM_CFG_SRC1_HI:`DAM_CFG_SRC1_LO]),
		.dynamic    (cfg_r[`DAM_CFG_DYN1]),
		.thr        (thr1_r),
		.win        (cnt1_r[`DAM_CNT_HI:0]),
		.hit_r      (hit[0])
	);

	dam_channel u_ch2 (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.sample_stb (sample_stb),
		.src_bus    (src_bus),
		.src_sel    (cfg_r[`DAM_CFG_SRC2_HI:`DAM_CFG_SRC2_LO]),
		.dynamic    (cfg_r[`DAM_CFG_DYN2]),
		.thr        (thr2_r),
		.win        (cnt2_r[`DAM_CNT_HI:0]),
		.hit_r      (hit[1])
	);

	assign rd_stat = reg_rd && sel_hit(reg_addr, `DAM_OFS_STAT);

	// Flags set two cycles after the sample's compare settles
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			upd_r <= 2'b00;
			hit_q_r <= 2'b00;
		end
		else
		begin
			upd_r <= {upd_r[0], sample_stb};
			hit_q_r <= hit;
		end
	end

	// Set wins over the read-clear in the same cycle
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			flag_r <= 2'b00;
		else if (upd_r[1])
			flag_r <= (rd_stat ? 2'b00 : flag_r) | hit_q_r;
		else if (rd_stat)
			flag_r <= 2'b00;
	end

	// Read mux; unmapped offsets read zero
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			reg_rdata_r <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
			`DAM_OFS_THR1: reg_rdata_r <= thr1_r;
			`DAM_OFS_THR2: reg_rdata_r <= thr2_r;
			`DAM_OFS_CNT1: reg_rdata_r <= cnt1_r;
			`DAM_OFS_CNT2: reg_rdata_r <= cnt2_r;
			`DAM_OFS_CFG:  reg_rdata_r <= cfg_r;
			// Channel 1 at bit 8, channel 2 at bit 9
			`DAM_OFS_STAT: reg_rdata_r <= {6'h00, flag_r, 8'h00};
			default:       reg_rdata_r <= 16'h0000;
			endcase
		end
	end

	// Live condition, not the sticky flag, drives the pin
	assign ind_act = |hit;
	assign ind_lvl = cfg_r[`DAM_CFG_IND_POL] ? ind_act : ~ind_act;

	// Misc control outranks the alarm on either pin
	assign alarm_own_one = cfg_r[`DAM_CFG_IND_EN]
		&& !cfg_r[`DAM_CFG_IND_SEL] && !misc_own_one;
	assign alarm_own_two = cfg_r[`DAM_CFG_IND_EN]
		&& cfg_r[`DAM_CFG_IND_SEL] && !misc_own_two;

	// Misc-owned pins are driven elsewhere; only alarm and I/O here
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			gp_one_out_r <= 1'b0;
			gp_one_oe_n_r <= 1'b1;
			gp_two_out_r <= 1'b0;
			gp_two_oe_n_r <= 1'b1;
		end
		else
		begin
			if (alarm_own_one)
			begin
				gp_one_out_r <= ind_lvl;
				gp_one_oe_n_r <= 1'b0;
			end
			else
			begin
				gp_one_out_r <= gpio_do_one;
				gp_one_oe_n_r <= misc_own_one | ~gpio_oe_one;
			end
			if (alarm_own_two)
			begin
				gp_two_out_r <= ind_lvl;
				gp_two_oe_n_r <= 1'b0;
			end
			else
			begin
				gp_two_out_r <= gpio_do_two;
				gp_two_oe_n_r <= misc_own_two | ~gpio_oe_two;
			end
		end
	end

endmodule

`default_nettype wire

//--- verification/dam_checker.sv
// Checker for dam_top: register port, status clear, pin ownership.
// Assumes it is bound to dam_top and sees only its ports.
`include "dam_defs.vh"
`default_nettype none

module dam_checker (
	input wire logic        ref_clk,       // Clock
	input wire logic        rst_n,         // Sync reset, active low
	input wire logic        reg_wr,        // Write strobe
	input wire logic        reg_rd,        // Read strobe
	input wire logic [6:0]  reg_addr,      // Offset
	input wire logic [15:0] reg_wdata,     // Write data
	input wire logic [15:0] reg_rdata_r,   // Read data
	input wire logic        sample_stb,    // Sample strobe
	input wire logic        misc_own_one,  // Misc owns pin one
	input wire logic        misc_own_two,  // Misc owns pin two
	input wire logic        alarm_own_one, // Alarm owns pin one
	input wire logic        alarm_own_two, // Alarm owns pin two
	input wire logic        gp_one_oe_n_r, // Pin one enable
	input wire logic        gp_two_oe_n_r  // Pin two enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cfg_r;
	wire         st_rd = reg_rd && reg_addr == `DAM_OFS_STAT;
	wire         mapped = reg_addr inside {7'h26, 7'h28, 7'h2a, 7'h2c,
		7'h2e, 7'h3c};
	always @(posedge ref_clk)
		if (!rst_n)
			cfg_r <= 16'h0000;
		else if (reg_wr && reg_addr == `DAM_OFS_CFG)
			cfg_r <= reg_wdata;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Flags set two edges after a strobe, so the quiet span covers that
	sequence s_quiet_rd;
		(!sample_stb)[*4] ##0 st_rd;
	endsequence
	sequence s_gap_rd;
		(!sample_stb && !reg_rd) ##1 (st_rd && !sample_stb);
	endsequence
	a_stat_clear: assert property (s_quiet_rd ##1 s_gap_rd |=>
		reg_rdata_r == 16'h0000) else $error("status not cleared");
	a_stat_bits: assert property (st_rd |=> reg_rdata_r[15:10] == 6'h00
		&& reg_rdata_r[7:0] == 8'h00) else $error("stray status bit");
	a_rd_cfg: assert property (reg_rd && !reg_wr &&
		reg_addr == `DAM_OFS_CFG |=> reg_rdata_r == $past(cfg_r))
		else $error("config readback wrong");
	a_rd_unmap: assert property (reg_rd && !mapped |=>
		reg_rdata_r == 16'h0000) else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_r))
		else $error("read data moved");
	a_own_one: assert property (alarm_own_one == (cfg_r[2] &&
		!cfg_r[0] && !misc_own_one)) else $error("pin one owner wrong");
	a_own_two: assert property (alarm_own_two == (cfg_r[2] &&
		cfg_r[0] && !misc_own_two)) else $error("pin two owner wrong");
	a_misc_one: assert property (misc_own_one |=> gp_one_oe_n_r)
		else $error("pin one not released");
	a_misc_two: assert property (misc_own_two |=> gp_two_oe_n_r)
		else $error("pin two not released");
endmodule

bind dam_top dam_checker i_dam_checker (.ref_clk, .rst_n, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r, .sample_stb,
	.misc_own_one, .misc_own_two, .alarm_own_one, .alarm_own_two,
	.gp_one_oe_n_r, .gp_two_oe_n_r);
`default_nettype wire

//--- verification/dam_host.sv
// Host model driving the register port of dam_top.
// Assumes callers enter its tasks 1 ns after a rising edge.
`default_nettype none

module dam_host (
	input  wire logic        ref_clk,     // Clock
	input  wire logic [15:0] reg_rdata_r, // Read data
	output var  logic        reg_wr,      // Write strobe
	output var  logic        reg_rd,      // Read strobe
	output var  logic [6:0]  reg_addr,    // Offset
	output var  logic [15:0] reg_wdata    // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	// Idle data is inverted so a stale value never looks valid
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk) #1 reg_wr = 1'b0;
		reg_wdata = ~d;
		// Idle edge: a following call never re-raises a strobe at once
		@(posedge ref_clk) #1;
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk) #1 reg_rd = 1'b0;
		d = reg_rdata_r;
		@(posedge ref_clk) #1;
	endtask
endmodule
`default_nettype wire

//--- verification/tb_dam_top.sv
// Testbench for dam_top: random configs and samples, flags and pins.
// Assumes dam_checker is bound in its own file.
`include "dam_defs.vh"
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	failures++; $display("[ERR] %s exp %h got %h", n, e, s); end end

module tb_dam_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic         ref_clk, rst_n, sample_stb, reg_wr, reg_rd, act;
	logic [6:0]   reg_addr;
	logic [15:0]  reg_wdata, reg_rdata_r, cfg, rv, thr[2], wv[5];
	logic [111:0] raw_bus, filt_bus;
	logic [1:0]   misc, goe, gdo, own, oen, pout;
	logic [7:0]   win[2];
	logic [3:0]   src[2];
	int           failures, comparisons, raw[7], flt[7], hist[2][9];
	logic [6:0]   ofs[7] = '{7'h26, 7'h28, 7'h2a, 7'h2c, 7'h2e, 7'h3c, 7'h30};
	dam_top i_dam_top (.ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata_r, .sample_stb, .raw_bus, .filt_bus,
		.misc_own_one(misc[0]), .misc_own_two(misc[1]),
		.gpio_oe_one(goe[0]), .gpio_oe_two(goe[1]),
		.gpio_do_one(gdo[0]), .gpio_do_two(gdo[1]),
		.alarm_own_one(own[0]), .alarm_own_two(own[1]),
		.gp_one_out_r(pout[0]), .gp_one_oe_n_r(oen[0]),
		.gp_two_out_r(pout[1]), .gp_two_oe_n_r(oen[1]));
	dam_host i_dam_host (.ref_clk, .reg_rdata_r, .reg_wr, .reg_rd,
		.reg_addr, .reg_wdata);
	always_comb
		for (int k = 0; k < 7; k++)
		begin
			raw_bus[16*k +: 16] = raw[k][15:0];
			filt_bus[16*k +: 16] = flt[k][15:0];
		end
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic cmp(int v, logic [15:0] t);
		return t[15] ? v > int'(t[13:0]) : v < int'(t[13:0]);
	endfunction
	function automatic logic exp_hit(int c, int k);
		int n;
		n = (win[c] < 2) ? 1 : win[c];
		if (src[c] == 0 || src[c] > 7)
			return 1'b0;
		if (!cfg[6 + c])
			return cmp(hist[c][k], thr[c]);
		return k > n && cmp(hist[c][k] - hist[c][k - n], thr[c]);
	endfunction
	task automatic check_pin(int p);
		logic al;
		logic drv;
		al = !misc[p] && cfg[2] && cfg[0] == p;
		drv = al || !misc[p] && goe[p];
		`CHK("own", al, own[p])
		`CHK("oe_n", !drv, oen[p])
		if (drv)
			`CHK("pin", al ? act ~^ cfg[1] : gdo[p], pout[p])
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		{rst_n, sample_stb, misc, goe, gdo} = '0;
		void'($urandom(32'h24dd));
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		foreach (ofs[i])
		begin
			i_dam_host.rd(ofs[i], rv);
			`CHK("reset", 16'h0000, rv)
		end
		for (int r = 0; r < 8; r++)
		begin
			src = '{4'(r), 4'(7 - r)};
			win = '{8'(r % 4), 8'(3 - r % 4)};
			for (int c = 0; c < 2; c++)
				thr[c] = {1'($urandom), 1'b0, 14'($urandom_range(300))};
			cfg = {src[1], src[0], 1'(r), 1'(~r), 1'b0, 1'(r >> 1), 1'b0,
				1'(r != 5), 1'(r >> 2), 1'($urandom)};
			{misc, goe, gdo} = 6'($urandom);
			wv = '{thr[0], thr[1], {8'h00, win[0]}, {8'h00, win[1]}, cfg};
			for (int i = 0; i < 5; i++)
				i_dam_host.wr(ofs[i], wv[i]);
			for (int i = 0; i < 5; i++)
			begin
				i_dam_host.rd(ofs[i], rv);
				`CHK("readback", wv[i], rv)
			end
			for (int k = 1; k < 9; k++)
			begin
				foreach (raw[j])
				begin
					raw[j] = int'($urandom_range(800)) - 400;
					flt[j] = int'($urandom_range(800)) - 400;
				end
				for (int c = 0; c < 2; c++)
					hist[c][k] = cfg[4] ? flt[(src[c] + 6) % 7] :
						raw[(src[c] + 6) % 7];
				sample_stb = 1'b1;
				@(posedge ref_clk) #1 sample_stb = 1'b0;
				repeat (2) @(posedge ref_clk);
				#1 act = exp_hit(0, k) | exp_hit(1, k);
				check_pin(0);
				check_pin(1);
				@(posedge ref_clk) #1;
				i_dam_host.rd(`DAM_OFS_STAT, rv);
				`CHK("flags", {6'h00, exp_hit(1, k), exp_hit(0, k), 8'h00}, rv)
				i_dam_host.rd(`DAM_OFS_STAT, rv);
				`CHK("cleared", 16'h0000, rv)
			end
		end
		report_and_stop;
	end
	// About seventy times the expected run
	initial
	begin
		#200000;
		failures++;
		report_and_stop;
	end
endmodule
`default_nettype wire
